// >>> core/frif_framer.sv
// Builds input frames 101 (fragmented result) and 102 (with switching I/O status)
`timescale 1ns/1ns
`default_nettype none
module frif_framer
  import frif_pkg::*;
#(
  parameter int MAXP = FRIF_MAX_PAYLOAD
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire logic        swio_frame_i,
  input  wire logic [8:0]  frame_len_i,
  input  wire logic [7:0]  dev_status_i,
  input  wire logic        acc_toggle_i,
  input  wire logic        rej_toggle_i,
  input  wire logic [2:0]  err_code_i,
  input  wire logic [7:0]  frag_num_i,
  input  wire logic [7:0]  frag_rem_i,
  input  wire logic [7:0]  frag_size_i,
  input  wire logic [7:0]  num_results_i,
  input  wire logic [5:0]  res_flags_i,
  input  wire logic [15:0] res_len_i,
  input  wire logic [3:0]  io_status_i,
  input  wire logic [3:0]  cmp_state_i,
  input  wire logic [3:0]  cmp_toggle_i,
  output logic [7:0]       pay_addr_o,
  input  wire logic [7:0]  pay_data_i,
  output logic             busy_o,
  output logic             len_err_o,
  output logic [7:0]       tx_data_o,
  output logic             tx_last_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i
);
  typedef enum logic [0:0] {
    FRIF_IDLE = 1'b0,
    FRIF_SEND = 1'b1
  } frif_state_t;

  frif_state_t state_r, state_nxt;
  logic [8:0]  idx_r, idx_nxt;
  logic [8:0]  len_r, len_nxt;
  logic        swio_r, swio_nxt;
  logic        err_r, err_nxt;
  logic [7:0]  paddr_r, paddr_nxt;
  logic [7:0]  byte_val;
  logic [8:0]  base;
  logic [8:0]  hdr;
  logic [8:0]  pidx;
  logic [7:0]  swio_lo, swio_hi;
  logic [15:0] swio_word;
  logic [7:0]  hsk_byte;
  logic [7:0]  rstat_byte;
  logic        pay_live;
  logic        push;

  frif_stream_if st ();
  logic [8:0]  buf_out;
  logic        buf_valid_q;

  // Channel nibbles: status, compare state, compare toggle, reserved
  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    assign swio_word[4*ch +: 4] = {1'b0, cmp_toggle_i[ch], cmp_state_i[ch], io_status_i[ch]};
  end
  assign swio_lo = swio_word[7:0];
  assign swio_hi = swio_word[15:8];

  always_comb begin
    hsk_byte = 8'h00;
    hsk_byte[FRIF_HSK_ACC_BIT] = acc_toggle_i;
    hsk_byte[FRIF_HSK_REJ_BIT] = rej_toggle_i;
    hsk_byte[FRIF_HSK_ERR_LSB +: 3] = err_code_i;
  end

  assign rstat_byte = {2'b00, res_flags_i};

  assign base = swio_r ? 9'(FRIF_BASE_SWIO) : 9'(FRIF_BASE_FRAG);
  assign hdr  = swio_r ? 9'(FRIF_HDR_SWIO) : 9'(FRIF_HDR_FRAG);
  assign pidx = idx_r - hdr;
  // Only meaningful past the header; the header cases win in the decoder below
  assign pay_live = ({7'd0, pidx} < res_len_i);

  // Header positions are taken from a base so both layouts share one decoder

  always_comb begin
    byte_val = 8'h00;
    if (idx_r == 9'(FRIF_OFS_STAT)) begin
      byte_val = dev_status_i;
    end else if (swio_r && idx_r == 9'(FRIF_OFS_SWIO_LO)) begin
      byte_val = swio_lo;
    end else if (swio_r && idx_r == 9'(FRIF_OFS_SWIO_HI)) begin
      byte_val = swio_hi;
    end else if (idx_r == base + 9'(FRIF_REL_HSK)) begin
      byte_val = hsk_byte;
    end else if (idx_r == base + 9'(FRIF_REL_FNUM)) begin
      byte_val = frag_num_i;
    end else if (idx_r == base + 9'(FRIF_REL_FREM)) begin
      byte_val = frag_rem_i;
    end else if (idx_r == base + 9'(FRIF_REL_FSIZE)) begin
      byte_val = frag_size_i;
    end else if (idx_r == base + 9'(FRIF_REL_NRES)) begin
      byte_val = num_results_i;
    end else if (idx_r == base + 9'(FRIF_REL_RSTAT)) begin
      byte_val = rstat_byte;
    end else if (idx_r == base + 9'(FRIF_REL_LEN_LO)) begin
      byte_val = res_len_i[7:0];
    end else if (idx_r == base + 9'(FRIF_REL_LEN_HI)) begin
      byte_val = res_len_i[15:8];
    end else if (pay_live) begin
      byte_val = pay_data_i;
    end else begin
      byte_val = 8'h00;
    end
  end

  assign push          = (state_r == FRIF_SEND) && st.ready;
  assign st.valid      = (state_r == FRIF_SEND);
  assign st.data       = byte_val;
  assign st.last       = (idx_r == len_r - 9'd1);

  // Field inputs are read live; the source holds them for the whole frame
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    len_nxt   = len_r;
    swio_nxt  = swio_r;
    err_nxt   = err_r;
    paddr_nxt = paddr_r;
    case (state_r)
      FRIF_IDLE: begin
        if (start_i) begin
          // Zero or oversize lengths are refused so that a frame never runs past the payload; short lengths are taken
          if (frame_len_i == 9'd0 ||
              frame_len_i > (swio_frame_i ? 9'(FRIF_MAX_SWIO) : 9'(FRIF_MAX_FRAG))) begin
            err_nxt = 1'b1;
          end else begin
            err_nxt   = 1'b0;
            len_nxt   = frame_len_i;
            swio_nxt  = swio_frame_i;
            idx_nxt   = 9'd0;
            paddr_nxt = 8'h00;
            state_nxt = FRIF_SEND;
          end
        end
      end
      FRIF_SEND: begin
        if (push) begin
          idx_nxt = idx_r + 9'd1;
          // Saturates rather than wrapping back onto data byte 0
          if (idx_r >= hdr && paddr_r != 8'(MAXP)) begin
            paddr_nxt = paddr_r + 8'd1;
          end
          if (st.last) begin
            state_nxt = FRIF_IDLE;
          end
        end
      end
      default: state_nxt = FRIF_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= FRIF_IDLE;
      idx_r   <= 9'd0;
      len_r   <= 9'd1;
      swio_r  <= 1'b0;
      err_r   <= 1'b0;
      paddr_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      len_r   <= len_nxt;
      swio_r  <= swio_nxt;
      err_r   <= err_nxt;
      paddr_r <= paddr_nxt;
    end
  end

  // Payload address is registered; the source must answer within the same cycle
  assign pay_addr_o = paddr_r;

  frif_skid_buf #(
    .W (9)
  ) u_buf (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_data_i   ({st.last, st.data}),
    .in_valid_i  (st.valid),
    .in_ready_o  (st.ready),
    .out_data_o  (buf_out),
    .out_valid_o (buf_valid_q),
    .out_ready_i (tx_ready_i)
  );

  assign tx_data_o  = buf_out[7:0];
  assign tx_last_o  = buf_out[8];
  assign tx_valid_o = buf_valid_q;
  assign busy_o     = (state_r == FRIF_SEND);
  assign len_err_o  = err_r;
endmodule
`default_nettype wire

// >>> core/frif_pkg.sv
// Constants for the fragmented result input frame builder
package frif_pkg;
  localparam logic [7:0] FRIF_INST_FRAG   = 8'h65;  // 101
  localparam logic [7:0] FRIF_INST_SWIO   = 8'h66;  // 102
  localparam int         FRIF_MAX_FRAG    = 264;
  localparam int         FRIF_MAX_SWIO    = 266;
  localparam int         FRIF_HDR_FRAG    = 9;
  localparam int         FRIF_HDR_SWIO    = 11;
  localparam int         FRIF_MAX_PAYLOAD = 255;
  localparam int         FRIF_OFS_STAT    = 0;
  localparam int         FRIF_OFS_SWIO_LO = 1;
  localparam int         FRIF_OFS_SWIO_HI = 2;
  // Offsets from the start of the common block, which sits at byte 1 or byte 3
  localparam int         FRIF_REL_HSK     = 0;
  localparam int         FRIF_REL_FNUM    = 1;
  localparam int         FRIF_REL_FREM    = 2;
  localparam int         FRIF_REL_FSIZE   = 3;
  localparam int         FRIF_REL_NRES    = 4;
  localparam int         FRIF_REL_RSTAT   = 5;
  localparam int         FRIF_REL_LEN_LO  = 6;
  localparam int         FRIF_REL_LEN_HI  = 7;
  localparam int         FRIF_BASE_FRAG   = 1;
  localparam int         FRIF_BASE_SWIO   = 3;
  localparam int         FRIF_HSK_ACC_BIT = 0;
  localparam int         FRIF_HSK_REJ_BIT = 1;
  localparam int         FRIF_HSK_ERR_LSB = 4;
  localparam int         FRIF_BUF_DEPTH   = 2;
endpackage

// >>> core/frif_stream_if.sv
// Byte stream carrier between frame builder and output buffer
`timescale 1ns/1ns
`default_nettype none
interface frif_stream_if;
  logic [7:0] data;
  logic       last;
  logic       valid;
  logic       ready;
  modport src (output data, output last, output valid, input ready);
  modport snk (input data, input last, input valid, output ready);
endinterface
`default_nettype wire

// >>> core/frif_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module frif_skid_buf #(
  parameter int W = 9
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output var  logic         in_ready_o,
  output var  logic [W-1:0] out_data_o,
  output var  logic         out_valid_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] out_d_r, out_d_nxt;
  logic [W-1:0] sk_d_r, sk_d_nxt;
  logic         out_v_r, out_v_nxt;
  logic         sk_v_r, sk_v_nxt;
  logic         push;

  // Output entry is a register, so the data and valid seen outside come from flops
  assign in_ready_o  = !sk_v_r;
  assign out_valid_o = out_v_r;
  assign out_data_o  = out_d_r;
  assign push        = in_valid_i && !sk_v_r;

  always_comb begin
    out_d_nxt = out_d_r;
    out_v_nxt = out_v_r;
    sk_d_nxt  = sk_d_r;
    sk_v_nxt  = sk_v_r;
    if (!out_v_r || out_ready_i) begin
      if (sk_v_r) begin
        out_d_nxt = sk_d_r;
        out_v_nxt = 1'b1;
        sk_v_nxt  = 1'b0;
      end else begin
        out_d_nxt = in_data_i;
        out_v_nxt = push;
      end
    end else if (push) begin
      // Second entry only fills while the receiver stalls
      sk_d_nxt = in_data_i;
      sk_v_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_d_r <= '0;
      out_v_r <= 1'b0;
      sk_d_r  <= '0;
      sk_v_r  <= 1'b0;
    end else begin
      out_d_r <= out_d_nxt;
      out_v_r <= out_v_nxt;
      sk_d_r  <= sk_d_nxt;
      sk_v_r  <= sk_v_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> verif/frif_framer_props.sv
// Port checker for the frame builder
`timescale 1ns/1ns
`default_nettype none
module frif_framer_props (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       start_i,
  input wire logic       swio_frame_i,
  input wire logic [8:0] frame_len_i,
  input wire logic [7:0] dev_status_i,
  input wire logic       busy_o,
  input wire logic       len_err_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_last_o,
  input wire logic       tx_valid_o,
  input wire logic       tx_ready_i
);
  logic [8:0] idx_r, len_r, lim;
  logic       sw_r, go, ok;
  assign lim = swio_frame_i ? 9'h10A : 9'h108;
  assign go = start_i && !busy_o;
  assign ok = frame_len_i != 9'h000 && frame_len_i <= lim;
  // Byte position; only sound while each frame drains before the next start
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      idx_r <= 9'h000;
      len_r <= 9'h000;
      sw_r  <= 1'b0;
    end else begin
      if (go) begin
        len_r <= frame_len_i;
        sw_r  <= swio_frame_i;
      end
      if (tx_valid_o && tx_ready_i)
        idx_r <= tx_last_o ? 9'h000 : idx_r + 9'h001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_start_taken: assert property (go && ok |=> busy_o && !len_err_o)
    else $error("start lost");
  a_len_refused: assert property (go && !ok |=> len_err_o && !busy_o)
    else $error("bad length taken");
  a_status_first: assert property (go && ok && !tx_valid_o
    |=> ##1 tx_valid_o && tx_data_o == dev_status_i) else $error("byte 0 wrong");
  a_out_held: assert property (tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o)) else $error("byte dropped");
  a_last_place: assert property (tx_valid_o && tx_last_o |-> idx_r == len_r - 9'h001)
    else $error("last misplaced");
  a_rstat_rsvd: assert property (tx_valid_o && idx_r == (sw_r ? 9'h008 : 9'h006)
    |-> tx_data_o[7:6] == 2'h0) else $error("status spare bits set");
  a_hsk_rsvd: assert property (tx_valid_o && idx_r == (sw_r ? 9'h003 : 9'h001)
    |-> !tx_data_o[7] && tx_data_o[3:2] == 2'h0) else $error("handshake spare bits set");
  a_nibble_rsvd: assert property (tx_valid_o && sw_r && idx_r inside {9'h001, 9'h002}
    |-> !tx_data_o[7] && !tx_data_o[3]) else $error("channel spare bits set");
endmodule
bind frif_framer frif_framer_props u_props (.clk_i(clk_i), .reset_i(reset_i),
  .start_i(start_i), .swio_frame_i(swio_frame_i), .frame_len_i(frame_len_i),
  .dev_status_i(dev_status_i), .busy_o(busy_o), .len_err_o(len_err_o), .tx_data_o(tx_data_o),
  .tx_last_o(tx_last_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
`default_nettype wire

// >>> verif/frif_plc_sink.sv
// Controller-side reader collecting frame bytes
`timescale 1ns/1ns
`default_nettype none
module frif_plc_sink (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       stall_i,
  input  wire logic [7:0] data_i,
  input  wire logic       last_i,
  input  wire logic       valid_i,
  output var  logic       ready_o
);
  logic [7:0] got[$];
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_o <= 1'b0;
    end else begin
      // Slow reader drops ready every other cycle
      ready_o <= !stall_i || !ready_o;
      if (valid_i && ready_o)
        got.push_back(data_i);
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Bench for the frame builder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct {int s; int l; int r;} frif_row_t;
  logic        clk_i = 1'b0, reset_i = 1'b1, start_i = 1'b0, sw = 1'b0, stall = 1'b0;
  logic [8:0]  len = 9'h000;
  logic [15:0] rlen = 16'h0000;
  logic [7:0]  f = 8'h00, pa, td;
  logic        busy, lerr, tl, tv, tr;
  int          n_errors = 0, cmp_count = 0;
  frif_row_t   rows[9] = '{'{0, 1, 0}, '{1, 1, 0}, '{0, 9, 0}, '{0, 19, 10}, '{1, 21, 10},
                           '{0, 264, 255}, '{1, 266, 255}, '{0, 15, 3}, '{1, 7, 0}};
  always #20 clk_i = ~clk_i;
  frif_framer DUT (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .swio_frame_i(sw),
    .frame_len_i(len), .dev_status_i(f), .acc_toggle_i(f[0]), .rej_toggle_i(f[1]),
    .err_code_i(f[6:4]), .frag_num_i(f ^ 8'h11), .frag_rem_i(f ^ 8'h22),
    .frag_size_i(f ^ 8'h33), .num_results_i(f ^ 8'h44), .res_flags_i(f[5:0] ^ 6'h2A),
    .res_len_i(rlen), .io_status_i(f[3:0]), .cmp_state_i(f[7:4]), .cmp_toggle_i(~f[3:0]),
    .pay_addr_o(pa), .pay_data_i(pa ^ 8'h5A), .busy_o(busy), .len_err_o(lerr),
    .tx_data_o(td), .tx_last_o(tl), .tx_valid_o(tv), .tx_ready_i(tr));
  frif_plc_sink u_plc (.clk_i(clk_i), .reset_i(reset_i), .stall_i(stall), .data_i(td),
    .last_i(tl), .valid_i(tv), .ready_o(tr));
  function automatic logic [7:0] nib2(int c);
    return {1'b0, ~f[c+1], f[c+5], f[c+1], 1'b0, ~f[c], f[c+4], f[c]};
  endfunction
  function automatic logic [7:0] exp_b(int s, int r, int i);
    int k;
    k = i - (s ? 3 : 1);
    if (i == 0) return f;
    if (s && i < 3) return nib2(2 * i - 2);
    case (k)
      0: return {1'b0, f[6:4], 2'h0, f[1], f[0]};
      1, 2, 3, 4: return f ^ 8'(k * 8'h11);
      5: return {2'h0, f[5:0] ^ 6'h2A};
      6: return r[7:0];
      7: return r[15:8];
      default: return (k - 8 < r) ? 8'(k - 8) ^ 8'h5A : 8'h00;
    endcase
  endfunction
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Start held h edges; a changed length while busy must be ignored
  task automatic run(int s, int l, int r, int h, int e);
    int w;
    w = 0;
    u_plc.got.delete();
    @(posedge clk_i);
    sw <= s[0];
    len <= l[8:0];
    rlen <= r[15:0];
    start_i <= 1'b1;
    repeat (h) begin
      @(posedge clk_i);
      len <= 9'h005;
    end
    start_i <= 1'b0;
    while (u_plc.got.size() < e && w < 2000) begin
      @(negedge clk_i);
      w++;
    end
    repeat (4) @(negedge clk_i);
    chk(16'(u_plc.got.size()), 16'(e));
    chk(16'(lerr), 16'(e == 0));
    foreach (u_plc.got[i]) chk(u_plc.got[i], exp_b(s, r, i));
    $display("frame of %0d bytes done", l);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (rows[n]) begin
      @(posedge clk_i);
      f <= 8'(n * 37);
      stall <= n[0];
      run(rows[n].s, rows[n].l, rows[n].r, 1, rows[n].l);
    end
    run(0, 0, 0, 1, 0);
    run(0, 265, 0, 1, 0);
    run(1, 267, 0, 1, 0);
    run(0, 40, 16, 3, 40);
    @(posedge clk_i);
    len <= 9'h064;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b1;
    @(negedge clk_i);
    chk({tv, busy, lerr, pa}, 16'h0000);
    $display("mid-frame reset done");
    @(posedge clk_i);
    reset_i <= 1'b0;
    run(1, 14, 3, 1, 14);
    close_out();
  end
  initial begin
    #1000000;
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
